// >>> pin_sync.sv
// Three-flop synchroniser for pin inputs; a change is taken when stages 2 and 3 agree.
// Assumes clk_in domain and a synchronous active-high reset.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_out <= '0;
    end else if (ce_in) begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_out <= s3;
      end
    end
  end
endmodule

// >>> sram_ctrl_pkg.sv
// Package for the async SRAM host controller: pin widths, timings, states.
// Assumes a 250 MHz clock for all derived cycle counts.
package sram_ctrl_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int DEPTH = 8192;
  localparam int CLK_PERIOD_PS = 4000;
  // Times in ns, slow grade as default figures
  localparam int ADDR_TO_DATA_TIME_NS = 120;
  localparam int DRIVE_TO_DATA_TIME_NS = 50;
  localparam int DATA_HOLD_AFTER_ADDR_NS = 5;
  localparam int SELECT_TO_FLOAT_NS = 40;
  localparam int STROBE_TO_FLOAT_TIME_NS = 35;
  localparam int DATA_BEFORE_END_TIME_NS = 40;
  localparam int ADDR_TO_END_NS = 85;
  localparam int ADDR_HOLD_NS = 10;
  // Least times round up, read waits use the longest access times rounded up
  localparam int RD_CYC = (ADDR_TO_DATA_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLOAT_CYC = (SELECT_TO_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_CYC = (ADDR_TO_END_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DATA_CYC = (DATA_BEFORE_END_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CYC = (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_FLOAT = 3'b010,
    ST_WRITE = 3'b011,
    ST_HOLD = 3'b100
  } state_e;
endpackage

// >>> sram_host.sv
// Host controller driving an 8K x 8 asynchronous SRAM over its pins.
// Assumes the memory sits on the pins directly; the testbench resolves the data bus.
// Function
// - Address changes only while strobe inactive
// - Data valid before write end, held after
// - Address valid long enough before write end
// - Address held after write end
`timescale 1ns/100ps
module sram_host (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [sram_ctrl_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] req_wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [sram_ctrl_pkg::DATA_W-1:0] rdata_out,
  output logic [sram_ctrl_pkg::ADDR_W-1:0] addr_lines_out,
  output logic select_low_n_out,
  output logic select_high_out,
  output logic store_strobe_n_out,
  output logic drive_gate_n_out,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] data_pins_in,
  output logic [sram_ctrl_pkg::DATA_W-1:0] data_pins_out,
  output logic data_pins_oe_out
);
  import sram_ctrl_pkg::*;

  state_e state;
  logic [CNT_W-1:0] cnt;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] data_sync;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  pin_sync #(.WIDTH(DATA_W)) u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .d_in(data_pins_in),
    .q_out(data_sync)
  );

  // Sequencer and pin controls
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      cnt <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= '0;
      addr_lines_out <= '0;
      wdata <= '0;
      select_low_n_out <= 1'b1;
      select_high_out <= 1'b0;
      store_strobe_n_out <= 1'b1;
      drive_gate_n_out <= 1'b1;
      data_pins_out <= '0;
      data_pins_oe_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_in) begin
            // Strobe is high here, so address may move
            addr_lines_out <= req_addr_in;
            wdata <= req_wdata_in;
            busy_out <= 1'b1;
            select_low_n_out <= 1'b0;
            select_high_out <= 1'b1;
            if (req_write_in) begin
              // Address and selects settle a cycle before the strobe falls
              data_pins_out <= req_wdata_in;
              data_pins_oe_out <= 1'b1;
              cnt <= cyc(WR_CYC > DATA_CYC ? WR_CYC : DATA_CYC);
              state <= ST_WRITE;
            end else begin
              drive_gate_n_out <= 1'b0;
              // Margin covers access time plus three sync stages and agreement
              cnt <= cyc(RD_CYC + 6);
              state <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (cnt == '0) begin
            rdata_out <= data_sync;
            done_out <= 1'b1;
            select_low_n_out <= 1'b1;
            select_high_out <= 1'b0;
            drive_gate_n_out <= 1'b1;
            cnt <= cyc(FLOAT_CYC);
            state <= ST_FLOAT;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_FLOAT: begin
          if (cnt == '0) begin
            busy_out <= 1'b0;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_WRITE: begin
          if (store_strobe_n_out) begin
            store_strobe_n_out <= 1'b0;
          end else if (cnt == '0) begin
            store_strobe_n_out <= 1'b1;
            cnt <= cyc(HOLD_CYC);
            state <= ST_HOLD;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_HOLD: begin
          if (cnt == '0) begin
            select_low_n_out <= 1'b1;
            select_high_out <= 1'b0;
            data_pins_oe_out <= 1'b0;
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> sram_host_properties.sv
// Checker for the SRAM host pin sequencing.
// Assumes it is bound onto sram_host with ce_in held high.
`timescale 1ns/100ps
module sram_host_properties (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic done_out,
  input wire logic [sram_ctrl_pkg::ADDR_W-1:0] addr_lines_out,
  input wire logic select_low_n_out,
  input wire logic select_high_out,
  input wire logic store_strobe_n_out,
  input wire logic drive_gate_n_out,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] data_pins_out,
  input wire logic data_pins_oe_out
);
  import sram_ctrl_pkg::*;
  wire logic s = store_strobe_n_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_addr_steady: assert property (!s && $past(!s) |-> $stable(addr_lines_out))
    else $error("address moved in write");
  a_no_fight: assert property (data_pins_oe_out |-> drive_gate_n_out)
    else $error("bus driven with gate low");
  a_wdata_steady: assert property ($past(!s) |-> data_pins_oe_out && $stable(data_pins_out))
    else $error("write data not held");
  a_strobe_width: assert property ($fell(s) |-> (!s)[*8] ##1 (!s)[*8] ##1 (!s)[*6] ##1 s)
    else $error("strobe width wrong");
  a_addr_hold: assert property ($rose(s) |-> (!select_low_n_out && $stable(addr_lines_out))[*3])
    else $error("address hold short");
  a_sel_pair: assert property (select_low_n_out == !select_high_out)
    else $error("selects disagree");
  a_gate_read: assert property (!drive_gate_n_out |-> s && !select_low_n_out && select_high_out)
    else $error("gate low outside read");
  a_read_wait: assert property ($fell(drive_gate_n_out) |-> ##36 done_out)
    else $error("read done at wrong time");
  cover property ($rose(s));
  cover property ($fell(drive_gate_n_out));
  cover property (done_out);
endmodule

// >>> sram_host_test.sv
// Bench for the SRAM host: writes fill a shadow copy, and reads are checked against it.
// Assumes sram_model on the pins and ce_in held high.
`timescale 1ns/100ps
module sram_host_test;
  import sram_ctrl_pkg::*;
  logic clk_in = 0, srst_in = 1, req_in = 0, req_write_in = 0;
  logic [ADDR_W-1:0] req_addr_in = '0, a, addr;
  logic [DATA_W-1:0] req_wdata_in = '0, d, rdata_out, pins_out, q;
  logic [DATA_W-1:0] shadow [DEPTH];
  logic busy_out, done_out, sel_n, sel, we_n, oe_n, oe;
  int err_total = 0, checks_done = 0, seed = 54;
  wire logic [DATA_W-1:0] bus = oe ? pins_out : q;
  always #2 clk_in = ~clk_in;
  sram_host u_dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .req_in(req_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out), .addr_lines_out(addr),
    .select_low_n_out(sel_n), .select_high_out(sel), .store_strobe_n_out(we_n),
    .drive_gate_n_out(oe_n), .data_pins_in(bus), .data_pins_out(pins_out),
    .data_pins_oe_out(oe));
  sram_model u_mem (.addr_in(addr), .sel_n_in(sel_n), .sel_in(sel), .we_n_in(we_n),
    .oe_n_in(oe_n), .bus_in(bus), .q_out(q), .q_en_out());
  task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  function logic [DATA_W-1:0] expect_rd(input logic [ADDR_W-1:0] at);
    return shadow[at];
  endfunction
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task xfer(input logic w, input logic [ADDR_W-1:0] at, input logic [DATA_W-1:0] wd);
    int n;
    req_write_in = w;
    req_addr_in = at;
    req_wdata_in = wd;
    req_in = 1;
    @(posedge clk_in) #1 req_in = 0;
    for (n = 0; n < 60 && done_out !== 1'b1; n++) @(posedge clk_in) #1;
    check({7'h00, done_out}, 8'h01);
    if (w) shadow[at] = wd;
    else check(rdata_out, expect_rd(at));
    for (n = 0; n < 20 && busy_out !== 1'b0; n++) @(posedge clk_in) #1;
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    #1 srst_in = 0;
    xfer(1, 13'h0000, 8'h5a);
    xfer(1, 13'h1fff, 8'ha5);
    xfer(0, 13'h0000, 8'h00);
    xfer(0, 13'h1fff, 8'h00);
    repeat (40) begin
      a = 13'($random(seed));
      d = 8'($random(seed));
      xfer(1, a, d);
      xfer(1, ~a, ~d);
      xfer(0, a, 8'h00);
    end
    close_out;
  end
  initial begin
    #100000;
    err_total++;
    close_out;
  end
endmodule
bind sram_host sram_host_properties u_chk (.*);

// >>> sram_model.sv
// Behavioural 8K x 8 static memory on the host pins.
// Assumes the bench resolves the shared data bus from the host output enable alone; q_en_out is left open.
`timescale 1ns/100ps
module sram_model (
  input wire logic [sram_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic sel_n_in,
  input wire logic sel_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] bus_in,
  output logic [sram_ctrl_pkg::DATA_W-1:0] q_out,
  output logic q_en_out
);
  import sram_ctrl_pkg::*;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] slow;
  wire logic on = !sel_n_in && sel_in;
  assign q_en_out = on && we_n_in && !oe_n_in;
  assign #(ADDR_TO_DATA_TIME_NS) slow = mem[addr_in];
  // Floating bus shows the inverse
  assign q_out = q_en_out ? slow : ~slow;
  always @* if (on && !we_n_in) mem[addr_in] = bus_in;
endmodule
